/* hdl/tglid_map.vh */
// constants of the text and graphic display instruction decoder
`ifndef TGLID_MAP_VH
`define TGLID_MAP_VH

// instruction execution time and core clock rate
`define TGL_EXEC_TIME_US 72
`define TGL_CORE_CLK_MHZ 40
`define TGL_EXEC_CYC (`TGL_EXEC_TIME_US * `TGL_CORE_CLK_MHZ)
`define TGL_BUSY_CNT_W 12

// ram target spaces, upper bits of the word ram index
`define TGL_SPACE_TEXT 2'h0
`define TGL_SPACE_GLYPH 2'h1
`define TGL_SPACE_ICON 2'h2
`define TGL_SPACE_BITMAP 2'h3

// fill value of the clear instruction, space code in both bytes
`define TGL_SPACE_CODE 8'h20
`define TGL_TEXT_WORDS 7'h40

// instruction byte field positions
`define TGL_B_ADDR_TEXT 7
`define TGL_B_ADDR_GLYPH 6
`define TGL_B_FUNC 5
`define TGL_B_SHIFT 4
`define TGL_B_DISP 3
`define TGL_B_ENTRY 2
`define TGL_B_HOME 1
`define TGL_B_CLEAR 0
`define TGL_B_X_BITMAP 7
`define TGL_B_X_ICON 6
`define TGL_B_X_FUNC 5
`define TGL_B_X_SLEEP 3
`define TGL_B_X_REVERSE 2
`define TGL_B_X_SRSEL 1
`define TGL_B_X_STANDBY 0
`define TGL_F_WIDTH 4
`define TGL_F_SETSEL 2
`define TGL_F_GFX 1

// reset values
`define TGL_RST_BUS8 1'b1
`define TGL_RST_INCR 1'b1
`define TGL_RST_WAKE 1'b0

`endif

/* hdl/tglid_word_ram.v */
// word ram holding text, glyph and icon contents
`timescale 1ns/1ps
module tglid_word_ram #(
  parameter AW = 8,
  parameter DW = 16
) (
  input wire clk,
  input wire rst_b,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [DW-1:0] wdata,
  input wire [AW-1:0] raddr,
  output reg [DW-1:0] rdata
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // contents have no reset; only ram writes and the clear instruction define them
  always @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdata <= {DW{1'b0}};
    end
    else
    begin
      rdata <= mem[raddr];
    end
  end

endmodule

/* hdl/tglid_decoder.v */
// instruction decoder of a text and graphic dot-matrix display controller
//
// Operation
// - clear fills text ram with spaces, pointer to zero, direction increment
// - home sets pointer to zero, text ram untouched
// - pointer steps by direction after access; shift flag shifts display
// - display-on flag shows or blanks display, text ram kept
// - cursor shown when cursor flag set; blink flag blinks cursor character
// - shift instruction moves cursor and pointer, or display only
// - width bit selects eight-bit or four-bit host bus
// - set-select bit chooses extended or basic decode
// - glyph address loads six bits; host keeps scroll select low
// - text address loads pointer for four lines, two visible
// - status read gives pending flag and pointer; busy ignores instructions
// - ram words are two bytes; pointer steps after second byte
// - dummy read after address set; pointer steps after every second read
// - standby entered by instruction, left by any following one
// - scroll select routes address loads to scroll or icon/glyph
// - reverse toggles chosen line; selection and video reset normal
// - sleep instruction enters or leaves sleep; starts awake
// - extended function set enables graphics; starts disabled
// - icon/scroll address takes six scroll bits or four icon bits
// - bitmap address is vertical then horizontal write
// - bitmap writes step horizontal only, wrapping, never vertical
// - set-select bit is retained until rewritten
// - status byte has pending flag on top bit, pointer below
// - instruction identified by highest set data bit
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ps
`include "tglid_map.vh"
module tglid_decoder #(
  parameter EXEC_CYC = `TGL_EXEC_CYC
) (
  input wire CORE_CLK,
  input wire RST_B,
  input wire CMD_DATA_SEL,
  input wire BUS_RW,
  input wire BUS_EN,
  input wire [7:0] DB_IN,
  output reg [7:0] DB_OUT,
  output reg DB_OE,
  output reg PENDING_OP_FLAG,
  output reg DISP_ON,
  output reg CURSOR_ON,
  output reg BLINK_ON,
  output reg GRAPHICS_EN,
  output reg SLEEP_MODE,
  output reg STANDBY_MODE,
  output reg [3:0] REVERSE_LINES,
  output reg [5:0] SCROLL_ADDR,
  output reg SHIFT_LEFT,
  output reg SHIFT_RIGHT,
  output reg BMP_WE,
  output reg [6:0] BMP_ADDR_V,
  output reg [3:0] BMP_ADDR_H,
  output reg [15:0] BMP_WDATA
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  reg en_s1;
  reg en_s2;
  reg en_s3;
  reg rs_s1;
  reg rs_s2;
  reg rw_s1;
  reg rw_s2;
  reg [7:0] db_s1;
  reg [7:0] db_s2;

  always @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      en_s1 <= 1'b0;
      en_s2 <= 1'b0;
      en_s3 <= 1'b0;
      rs_s1 <= 1'b0;
      rs_s2 <= 1'b0;
      rw_s1 <= 1'b0;
      rw_s2 <= 1'b0;
      db_s1 <= 8'h00;
      db_s2 <= 8'h00;
    end
    else
    begin
      en_s1 <= BUS_EN;
      en_s2 <= en_s1;
      en_s3 <= en_s2;
      rs_s1 <= CMD_DATA_SEL;
      rs_s2 <= rs_s1;
      rw_s1 <= BUS_RW;
      rw_s2 <= rw_s1;
      db_s1 <= DB_IN;
      db_s2 <= db_s1;
    end
  end

  wire en_rise = en_s2 & ~en_s3;
  wire en_fall = ~en_s2 & en_s3;

  ////////////////////////////////////////////////////////////////////////
  // state
  reg bus8_reg;
  reg set_sel_reg;
  reg incr_reg;
  reg shift_acc_reg;
  reg sr_sel_reg;
  reg nib_reg;
  reg [3:0] nib_hi_reg;
  reg [6:0] ac_reg;
  reg [1:0] space_reg;
  reg dummy_reg;
  reg rd_lo_reg;
  reg wr_lo_reg;
  reg [7:0] wr_hi_reg;
  reg bmp_phase_reg;
  reg [1:0] line_sel_reg;
  reg clearing_reg;
  reg [5:0] clr_cnt_reg;
  reg [`TGL_BUSY_CNT_W-1:0] busy_cnt_reg;
  reg ram_we_reg;
  reg [7:0] ram_waddr_reg;
  reg [15:0] ram_wdata_reg;
  wire [15:0] ram_rdata;

  // text, glyph and icon share one ram; bitmap words leave on the bmp port
  tglid_word_ram #(
    .AW(8),
    .DW(16)
  ) u_ram (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .we(ram_we_reg),
    .waddr(ram_waddr_reg),
    .wdata(ram_wdata_reg),
    .raddr({space_reg, ac_reg[5:0]}),
    .rdata(ram_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // byte assembly and read byte
  wire last_part = bus8_reg | nib_reg;
  wire [7:0] in_byte = bus8_reg ? db_s2 : {nib_hi_reg, db_s2[7:4]};
  wire is_status = ~rs_s2 & rw_s2;
  // busy refuses everything but the status read
  wire accept = en_fall & last_part & (~PENDING_OP_FLAG | is_status);
  wire [7:0] data_byte = (space_reg == `TGL_SPACE_BITMAP) ? 8'h00 :
                         (rd_lo_reg ? ram_rdata[7:0] : ram_rdata[15:8]);
  wire [7:0] rd_byte = rs_s2 ? data_byte : {PENDING_OP_FLAG, ac_reg};
  wire [6:0] ac_step = incr_reg ? ac_reg + 7'h01 : ac_reg - 7'h01;
  wire [6:0] ac_inc = ac_reg + 7'h01;
  wire [6:0] ac_dec = ac_reg - 7'h01;
  wire [3:0] bmp_h_next = BMP_ADDR_H + 4'h1;
  localparam [31:0] EXEC_CYC_W = EXEC_CYC;
  wire [`TGL_BUSY_CNT_W-1:0] busy_load = EXEC_CYC_W[`TGL_BUSY_CNT_W-1:0];
  wire is_bmp = space_reg == `TGL_SPACE_BITMAP;

  ////////////////////////////////////////////////////////////////////////
  // main process
  always @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      bus8_reg <= `TGL_RST_BUS8;
      set_sel_reg <= 1'b0;
      incr_reg <= `TGL_RST_INCR;
      shift_acc_reg <= 1'b0;
      sr_sel_reg <= 1'b0;
      nib_reg <= 1'b0;
      nib_hi_reg <= 4'h0;
      ac_reg <= 7'h00;
      space_reg <= `TGL_SPACE_TEXT;
      dummy_reg <= 1'b0;
      rd_lo_reg <= 1'b0;
      wr_lo_reg <= 1'b0;
      wr_hi_reg <= 8'h00;
      bmp_phase_reg <= 1'b0;
      line_sel_reg <= 2'h0;
      clearing_reg <= 1'b0;
      clr_cnt_reg <= 6'h00;
      busy_cnt_reg <= {`TGL_BUSY_CNT_W{1'b0}};
      ram_we_reg <= 1'b0;
      ram_waddr_reg <= 8'h00;
      ram_wdata_reg <= 16'h0000;
      DB_OUT <= 8'h00;
      DB_OE <= 1'b0;
      PENDING_OP_FLAG <= 1'b0;
      DISP_ON <= 1'b0;
      CURSOR_ON <= 1'b0;
      BLINK_ON <= 1'b0;
      GRAPHICS_EN <= 1'b0;
      SLEEP_MODE <= `TGL_RST_WAKE;
      STANDBY_MODE <= 1'b0;
      REVERSE_LINES <= 4'h0;
      SCROLL_ADDR <= 6'h00;
      SHIFT_LEFT <= 1'b0;
      SHIFT_RIGHT <= 1'b0;
      BMP_WE <= 1'b0;
      BMP_ADDR_V <= 7'h00;
      BMP_ADDR_H <= 4'h0;
      BMP_WDATA <= 16'h0000;
    end
    else
    begin
      ram_we_reg <= 1'b0;
      SHIFT_LEFT <= 1'b0;
      SHIFT_RIGHT <= 1'b0;
      BMP_WE <= 1'b0;

      // read drive: nibbles on the upper lines, high nibble first
      if (en_rise & rw_s2)
      begin
        DB_OE <= 1'b1;
        if (bus8_reg)
        begin
          DB_OUT <= rd_byte;
        end
        else if (!nib_reg)
        begin
          DB_OUT <= {rd_byte[7:4], 4'h0};
        end
        else
        begin
          DB_OUT <= {rd_byte[3:0], 4'h0};
        end
      end
      else if (en_fall)
      begin
        DB_OE <= 1'b0;
      end

      if (en_fall & ~bus8_reg)
      begin
        nib_reg <= ~nib_reg;
        if (!nib_reg)
        begin
          nib_hi_reg <= db_s2[7:4];
        end
      end

      // pending flag runs the execution time, then drops
      if (busy_cnt_reg > {{(`TGL_BUSY_CNT_W-1){1'b0}}, 1'b1})
      begin
        busy_cnt_reg <= busy_cnt_reg - {{(`TGL_BUSY_CNT_W-1){1'b0}}, 1'b1};
      end
      else if (busy_cnt_reg != {`TGL_BUSY_CNT_W{1'b0}})
      begin
        busy_cnt_reg <= {`TGL_BUSY_CNT_W{1'b0}};
        PENDING_OP_FLAG <= 1'b0;
      end

      // clear sweep: one text word per cycle, well inside the busy time
      if (clearing_reg)
      begin
        ram_we_reg <= 1'b1;
        ram_waddr_reg <= {`TGL_SPACE_TEXT, clr_cnt_reg};
        ram_wdata_reg <= {`TGL_SPACE_CODE, `TGL_SPACE_CODE};
        clr_cnt_reg <= clr_cnt_reg + 6'h01;
        if (clr_cnt_reg == 6'h3F)
        begin
          clearing_reg <= 1'b0;
        end
      end

      if (accept & ~is_status)
      begin
        PENDING_OP_FLAG <= 1'b1;
        busy_cnt_reg <= busy_load;
        if (rs_s2 & rw_s2)
        begin
          // ram read: first read after an address set only primes
          if (dummy_reg)
          begin
            dummy_reg <= 1'b0;
          end
          else if (!rd_lo_reg)
          begin
            rd_lo_reg <= 1'b1;
          end
          else
          begin
            rd_lo_reg <= 1'b0;
            if (is_bmp)
            begin
              BMP_ADDR_H <= bmp_h_next;
            end
            else
            begin
              ac_reg <= ac_step;
            end
          end
        end
        else if (rs_s2)
        begin
          // ram write: two bytes per word, step after the second
          if (!wr_lo_reg)
          begin
            wr_lo_reg <= 1'b1;
            wr_hi_reg <= in_byte;
          end
          else
          begin
            wr_lo_reg <= 1'b0;
            if (is_bmp)
            begin
              BMP_WE <= 1'b1;
              BMP_WDATA <= {wr_hi_reg, in_byte};
              BMP_ADDR_H <= bmp_h_next;
            end
            else
            begin
              ram_we_reg <= 1'b1;
              ram_waddr_reg <= {space_reg, ac_reg[5:0]};
              ram_wdata_reg <= {wr_hi_reg, in_byte};
              ac_reg <= ac_step;
              SHIFT_LEFT <= shift_acc_reg & incr_reg;
              SHIFT_RIGHT <= shift_acc_reg & ~incr_reg;
            end
          end
        end
        else
        begin
          // any instruction other than standby ends standby
          STANDBY_MODE <= 1'b0;
          if (!(set_sel_reg & in_byte[`TGL_B_X_BITMAP]))
          begin
            bmp_phase_reg <= 1'b0;
          end
          if (!set_sel_reg)
          begin
            // basic set, highest set bit names the instruction
            if (in_byte[`TGL_B_ADDR_TEXT])
            begin
              ac_reg <= {1'b0, in_byte[5:0]};
              space_reg <= `TGL_SPACE_TEXT;
              dummy_reg <= 1'b1;
              rd_lo_reg <= 1'b0;
              wr_lo_reg <= 1'b0;
            end
            else if (in_byte[`TGL_B_ADDR_GLYPH])
            begin
              ac_reg <= {1'b0, in_byte[5:0]};
              space_reg <= `TGL_SPACE_GLYPH;
              dummy_reg <= 1'b1;
              rd_lo_reg <= 1'b0;
              wr_lo_reg <= 1'b0;
            end
            else if (in_byte[`TGL_B_FUNC])
            begin
              bus8_reg <= in_byte[`TGL_F_WIDTH];
              set_sel_reg <= in_byte[`TGL_F_SETSEL];
              nib_reg <= 1'b0;
            end
            else if (in_byte[`TGL_B_SHIFT])
            begin
              // s/c on bit 3, r/l on bit 2; ram never touched here
              if (in_byte[3])
              begin
                SHIFT_LEFT <= ~in_byte[2];
                SHIFT_RIGHT <= in_byte[2];
              end
              else if (in_byte[2])
              begin
                ac_reg <= ac_inc;
              end
              else
              begin
                ac_reg <= ac_dec;
              end
            end
            else if (in_byte[`TGL_B_DISP])
            begin
              DISP_ON <= in_byte[2];
              CURSOR_ON <= in_byte[1];
              BLINK_ON <= in_byte[0];
            end
            else if (in_byte[`TGL_B_ENTRY])
            begin
              incr_reg <= in_byte[1];
              shift_acc_reg <= in_byte[0];
            end
            else if (in_byte[`TGL_B_HOME])
            begin
              ac_reg <= 7'h00;
              space_reg <= `TGL_SPACE_TEXT;
            end
            else if (in_byte[`TGL_B_CLEAR])
            begin
              ac_reg <= 7'h00;
              space_reg <= `TGL_SPACE_TEXT;
              incr_reg <= 1'b1;
              clearing_reg <= 1'b1;
              clr_cnt_reg <= 6'h00;
            end
          end
          else
          begin
            // extended set
            if (in_byte[`TGL_B_X_BITMAP])
            begin
              // vertical first, then horizontal
              if (!bmp_phase_reg)
              begin
                BMP_ADDR_V <= in_byte[6:0];
                ac_reg <= in_byte[6:0];
                bmp_phase_reg <= 1'b1;
              end
              else
              begin
                BMP_ADDR_H <= in_byte[3:0];
                ac_reg <= {3'h0, in_byte[3:0]};
                bmp_phase_reg <= 1'b0;
              end
              space_reg <= `TGL_SPACE_BITMAP;
              dummy_reg <= 1'b1;
              rd_lo_reg <= 1'b0;
              wr_lo_reg <= 1'b0;
            end
            else if (in_byte[`TGL_B_X_ICON])
            begin
              if (sr_sel_reg)
              begin
                SCROLL_ADDR <= in_byte[5:0];
              end
              else
              begin
                ac_reg <= {3'h0, in_byte[3:0]};
                space_reg <= `TGL_SPACE_ICON;
                dummy_reg <= 1'b1;
                rd_lo_reg <= 1'b0;
                wr_lo_reg <= 1'b0;
              end
            end
            else if (in_byte[`TGL_B_X_FUNC])
            begin
              bus8_reg <= in_byte[`TGL_F_WIDTH];
              set_sel_reg <= in_byte[`TGL_F_SETSEL];
              GRAPHICS_EN <= in_byte[`TGL_F_GFX];
              nib_reg <= 1'b0;
            end
            else if (in_byte[`TGL_B_X_SLEEP])
            begin
              SLEEP_MODE <= ~in_byte[2];
            end
            else if (in_byte[`TGL_B_X_REVERSE])
            begin
              line_sel_reg <= in_byte[1:0];
              REVERSE_LINES[in_byte[1:0]] <= ~REVERSE_LINES[in_byte[1:0]];
            end
            else if (in_byte[`TGL_B_X_SRSEL])
            begin
              sr_sel_reg <= in_byte[0];
            end
            else if (in_byte[`TGL_B_X_STANDBY])
            begin
              STANDBY_MODE <= 1'b1;
            end
          end
        end
      end
    end
  end

endmodule

/* sim/tglid_decoder_sva.sv */
// port assertions of the display instruction decoder
`timescale 1ns/1ps
module tglid_decoder_sva #(
  parameter EXEC_CYC = 80
) (
  input wire CORE_CLK,
  input wire RST_B,
  input wire CMD_DATA_SEL,
  input wire BUS_RW,
  input wire BUS_EN,
  input wire DB_OE,
  input wire PENDING_OP_FLAG,
  input wire DISP_ON,
  input wire CURSOR_ON,
  input wire BLINK_ON,
  input wire GRAPHICS_EN,
  input wire SLEEP_MODE,
  input wire [3:0] REVERSE_LINES,
  input wire [5:0] SCROLL_ADDR,
  input wire SHIFT_LEFT,
  input wire SHIFT_RIGHT,
  input wire BMP_WE,
  input wire [6:0] BMP_ADDR_V,
  input wire [3:0] BMP_ADDR_H
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  // counts how long the pending flag has stood
  reg [15:0] busy_cnt_reg;
  always @(posedge CORE_CLK or negedge RST_B)
    if (!RST_B)
      busy_cnt_reg <= 16'h0000;
    else if (PENDING_OP_FLAG)
      busy_cnt_reg <= busy_cnt_reg + 16'h0001;
    else
      busy_cnt_reg <= 16'h0000;
  ////////////////////////////////////////////////////////////////////////////////
  a_busy_exact_len: assert property ($fell(PENDING_OP_FLAG) |-> busy_cnt_reg == EXEC_CYC)
    else $error("pending flag length differs from execution time");
  a_busy_no_overrun: assert property (busy_cnt_reg <= EXEC_CYC)
    else $error("pending flag stands too long");
  a_flags_hold_busy: assert property ($past(PENDING_OP_FLAG) |-> $stable({DISP_ON, CURSOR_ON,
    BLINK_ON, GRAPHICS_EN, SLEEP_MODE, REVERSE_LINES, SCROLL_ADDR}))
    else $error("display state changed while busy");
  a_status_drive: assert property ($rose(BUS_EN) && BUS_RW && !CMD_DATA_SEL |-> ##[1:4] DB_OE)
    else $error("status read not driven");
  a_oe_release: assert property ($fell(BUS_EN) |-> ##[1:4] !DB_OE)
    else $error("data bus not released");
  a_oe_read_only: assert property (DB_OE |-> BUS_RW)
    else $error("data bus driven during a write");
  a_shift_single: assert property ((SHIFT_LEFT || SHIFT_RIGHT) |->
    !(SHIFT_LEFT && SHIFT_RIGHT) ##1 !(SHIFT_LEFT || SHIFT_RIGHT))
    else $error("shift pulse malformed");
  a_bmp_h_step: assert property (BMP_WE |-> BMP_ADDR_H == $past(BMP_ADDR_H) + 4'h1)
    else $error("horizontal bitmap address did not step by one");
  a_bmp_v_kept: assert property (BMP_WE |-> $stable(BMP_ADDR_V) ##1 !BMP_WE)
    else $error("vertical bitmap address moved on a write");
  a_gfx_by_instr: assert property ($changed(GRAPHICS_EN) |-> $rose(PENDING_OP_FLAG))
    else $error("graphics enable changed without an instruction");
  a_sleep_by_instr: assert property ($changed(SLEEP_MODE) |-> $rose(PENDING_OP_FLAG))
    else $error("sleep state changed without an instruction");
  c_bmp_write: cover property (BMP_WE);
  c_busy_done: cover property ($fell(PENDING_OP_FLAG));
  c_status_read: cover property ($rose(DB_OE));
endmodule
bind tglid_decoder tglid_decoder_sva #(.EXEC_CYC(EXEC_CYC)) u_tglid_decoder_sva (
  .CORE_CLK(CORE_CLK), .RST_B(RST_B), .CMD_DATA_SEL(CMD_DATA_SEL), .BUS_RW(BUS_RW),
  .BUS_EN(BUS_EN), .DB_OE(DB_OE), .PENDING_OP_FLAG(PENDING_OP_FLAG), .DISP_ON(DISP_ON),
  .CURSOR_ON(CURSOR_ON), .BLINK_ON(BLINK_ON), .GRAPHICS_EN(GRAPHICS_EN),
  .SLEEP_MODE(SLEEP_MODE), .REVERSE_LINES(REVERSE_LINES), .SCROLL_ADDR(SCROLL_ADDR),
  .SHIFT_LEFT(SHIFT_LEFT), .SHIFT_RIGHT(SHIFT_RIGHT), .BMP_WE(BMP_WE),
  .BMP_ADDR_V(BMP_ADDR_V), .BMP_ADDR_H(BMP_ADDR_H));

/* sim/tglid_host_model.sv */
// host processor model driving the parallel instruction bus
`timescale 1ns/1ps
module tglid_host_model #(
  parameter WAIT_CYC = 100
) (
  input wire CORE_CLK,
  output logic CMD_DATA_SEL,
  output logic BUS_RW,
  output logic BUS_EN,
  output logic [7:0] DB_IN,
  input wire [7:0] DB_OUT
);
  logic bus4;
  initial
  begin
    bus4 = 1'b0;
    CMD_DATA_SEL = 1'b0;
    BUS_RW = 1'b0;
    BUS_EN = 1'b0;
    DB_IN = 8'hA5;
  end
  // controls settle an edge before the enable and are held well past its fall
  task strobe(input logic rs, input logic rw, input logic [7:0] d, output logic [7:0] q);
    @(posedge CORE_CLK);
    CMD_DATA_SEL <= rs;
    BUS_RW <= rw;
    DB_IN <= d;
    @(posedge CORE_CLK);
    BUS_EN <= 1'b1;
    repeat (5) @(posedge CORE_CLK);
    q = DB_OUT;
    BUS_EN <= 1'b0;
    repeat (5) @(posedge CORE_CLK);
    // released lines float, so show the inverse rather than a stale value
    DB_IN <= ~d;
  endtask
  task put(input logic rs, input logic [7:0] d);
    logic [7:0] q;
    if (bus4)
    begin
      strobe(rs, 1'b0, {d[7:4], ~d[7:4]}, q);
      strobe(rs, 1'b0, {d[3:0], ~d[3:0]}, q);
    end
    else
      strobe(rs, 1'b0, d, q);
  endtask
  task get(input logic rs, output logic [7:0] q);
    logic [7:0] h;
    if (bus4)
    begin
      strobe(rs, 1'b1, DB_IN, h);
      strobe(rs, 1'b1, DB_IN, q);
      q = {h[7:4], q[7:4]};
    end
    else
      strobe(rs, 1'b1, DB_IN, q);
  endtask
  // status reads need the full byte, so the nibble mode waits a fixed time
  task idle();
    logic [7:0] q;
    int n;
    q = 8'h80;
    n = 0;
    if (bus4)
      repeat (WAIT_CYC) @(posedge CORE_CLK);
    else
      while (q[7] && n < 60)
      begin
        get(1'b0, q);
        n++;
      end
  endtask
endmodule

/* sim/tglid_decoder_bench.sv */
// self-checking bench of the display instruction decoder
`timescale 1ns/1ps
module tglid_decoder_bench;
  logic core_clk;
  logic rst_b;
  wire cmd_data_sel;
  wire bus_rw;
  wire bus_en;
  wire [7:0] db_in;
  wire [7:0] db_out;
  wire db_oe;
  wire busy;
  wire disp_on;
  wire cursor_on;
  wire blink_on;
  wire gfx_en;
  wire sleep_mode;
  wire standby_mode;
  wire [3:0] rev_lines;
  wire [5:0] scroll_addr;
  wire shift_l;
  wire shift_r;
  wire [6:0] bmp_v;
  wire [3:0] bmp_h;
  wire [15:0] bmp_d;
  wire bmp_we;
  int fail_count = 0;
  int cmp_count = 0;
  int i;
  logic [7:0] q;
  logic sl_seen = 1'b0;
  logic sr_seen = 1'b0;
  logic [6:0] bv = 7'h00;
  logic [3:0] bh = 4'h0;
  logic [15:0] bd = 16'h0000;
  tglid_decoder #(.EXEC_CYC(80)) u_tglid_decoder (.CORE_CLK(core_clk), .RST_B(rst_b),
    .CMD_DATA_SEL(cmd_data_sel), .BUS_RW(bus_rw), .BUS_EN(bus_en), .DB_IN(db_in),
    .DB_OUT(db_out), .DB_OE(db_oe), .PENDING_OP_FLAG(busy), .DISP_ON(disp_on),
    .CURSOR_ON(cursor_on), .BLINK_ON(blink_on), .GRAPHICS_EN(gfx_en),
    .SLEEP_MODE(sleep_mode), .STANDBY_MODE(standby_mode), .REVERSE_LINES(rev_lines),
    .SCROLL_ADDR(scroll_addr), .SHIFT_LEFT(shift_l), .SHIFT_RIGHT(shift_r), .BMP_WE(bmp_we),
    .BMP_ADDR_V(bmp_v), .BMP_ADDR_H(bmp_h), .BMP_WDATA(bmp_d));
  tglid_host_model #(.WAIT_CYC(100)) u_tglid_host_model (.CORE_CLK(core_clk),
    .CMD_DATA_SEL(cmd_data_sel), .BUS_RW(bus_rw), .BUS_EN(bus_en), .DB_IN(db_in),
    .DB_OUT(db_out));
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    if (shift_l) sl_seen <= 1'b1;
    if (shift_r) sr_seen <= 1'b1;
    if (bmp_we) {bv, bh, bd} <= {bmp_v, bmp_h, bmp_d};
  end
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input string what, input logic [15:0] e, input logic [15:0] got);
    cmp_count++;
    if (got !== e)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, e, got);
    end
  endtask
  // each instruction sent by cmd waits for idle before and after, so outputs have settled
  task cmd(input logic [7:0] d);
    u_tglid_host_model.idle();
    u_tglid_host_model.put(1'b0, d);
    u_tglid_host_model.idle();
  endtask
  task wr(input logic [7:0] d);
    u_tglid_host_model.idle();
    u_tglid_host_model.put(1'b1, d);
  endtask
  task rd(input logic [7:0] e);
    u_tglid_host_model.idle();
    u_tglid_host_model.get(1'b1, q);
    chk("ram byte", {8'h00, e}, {8'h00, q});
  endtask
  task ptr(input logic [6:0] e);
    u_tglid_host_model.idle();
    u_tglid_host_model.get(1'b0, q);
    chk("status", {9'h000, e}, {8'h00, q});
  endtask
  task summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge core_clk);
    fail_count++;
    $display("MISMATCH watchdog expected finish seen hang");
    summarize();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_b = 1'b0;
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    chk("reset flags", 16'h0000, {6'h00, disp_on, cursor_on, blink_on, gfx_en, sleep_mode,
      standby_mode, rev_lines});
    for (i = 0; i < 8; i++)
    begin
      cmd(8'h08 | i[7:0]);
      chk("display", {13'h0000, i[2:0]}, {13'h0000, disp_on, cursor_on, blink_on});
    end
    u_tglid_host_model.put(1'b0, 8'h0C);
    u_tglid_host_model.get(1'b0, q);
    chk("busy", 16'h0001, {15'h0000, q[7]});
    u_tglid_host_model.put(1'b0, 8'h0F);
    u_tglid_host_model.idle();
    chk("ignored", 16'h0002, {14'h0000, disp_on, cursor_on});
    cmd(8'h01);
    ptr(7'h00);
    cmd(8'h90);
    ptr(7'h10);
    wr(8'h41);
    ptr(7'h10);
    wr(8'h42);
    ptr(7'h11);
    cmd(8'h04);
    wr(8'h43);
    wr(8'h44);
    ptr(7'h10);
    cmd(8'h10);
    ptr(7'h0F);
    cmd(8'h14);
    ptr(7'h10);
    sl_seen = 1'b0;
    cmd(8'h18);
    ptr(7'h10);
    chk("shift", 16'h0002, {14'h0000, sl_seen, sr_seen});
    sl_seen = 1'b0;
    cmd(8'h1C);
    ptr(7'h10);
    chk("shift right", 16'h0001, {14'h0000, sl_seen, sr_seen});
    cmd(8'h02);
    ptr(7'h00);
    sl_seen = 1'b0;
    cmd(8'h07);
    wr(8'h45);
    wr(8'h46);
    ptr(7'h01);
    chk("access shift", 16'h0001, {15'h0000, sl_seen});
    cmd(8'h06);
    cmd(8'h90);
    u_tglid_host_model.idle();
    u_tglid_host_model.get(1'b1, q);
    rd(8'h41);
    rd(8'h42);
    rd(8'h43);
    rd(8'h44);
    ptr(7'h12);
    cmd(8'h81);
    u_tglid_host_model.idle();
    u_tglid_host_model.get(1'b1, q);
    rd(8'h20);
    rd(8'h20);
    cmd(8'h45);
    ptr(7'h05);
    // width kept, set select changed alone, then graphics alone
    cmd(8'h34);
    cmd(8'h36);
    chk("graphics", 16'h0001, {15'h0000, gfx_en});
    for (i = 0; i < 4; i++)
      cmd(8'h04 | i[7:0]);
    chk("reverse", 16'h000F, {12'h000, rev_lines});
    cmd(8'h05);
    chk("reverse", 16'h000D, {12'h000, rev_lines});
    cmd(8'h08);
    chk("sleep", 16'h0001, {15'h0000, sleep_mode});
    cmd(8'h01);
    chk("standby", 16'h0003, {14'h0000, sleep_mode, standby_mode});
    cmd(8'h0C);
    chk("wake", 16'h0000, {14'h0000, sleep_mode, standby_mode});
    cmd(8'h03);
    cmd(8'h6A);
    chk("scroll", 16'h002A, {10'h000, scroll_addr});
    cmd(8'h02);
    cmd(8'h5A);
    ptr(7'h0A);
    cmd(8'h85);
    cmd(8'h8F);
    wr(8'h12);
    wr(8'h34);
    u_tglid_host_model.idle();
    chk("bitmap addr", 16'h0050, {5'h00, bv, bh});
    chk("bitmap data", 16'h1234, bd);
    wr(8'h56);
    wr(8'h78);
    u_tglid_host_model.idle();
    chk("bitmap addr", 16'h0051, {5'h00, bv, bh});
    chk("bitmap data", 16'h5678, bd);
    cmd(8'h32);
    // byte-wide polls would desync the nibble phase, so the model follows the width first
    u_tglid_host_model.idle();
    u_tglid_host_model.put(1'b0, 8'h20);
    u_tglid_host_model.bus4 = 1'b1;
    cmd(8'h0F);
    chk("nibble mode", 16'h0007, {13'h0000, disp_on, cursor_on, blink_on});
    ptr(7'h0F);
    summarize();
  end
endmodule
